// File: logic/tcp_defines.vh
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCP_OFF_CTRL   8'h00
`define TCP_OFF_COUNT  8'h04
`define TCP_OFF_MATCH  8'h08
`define TCP_OFF_RELOAD 8'h0C
`define TCP_OFF_STATUS 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TCP_CTRL_EN     0
`define TCP_CTRL_POL    1
`define TCP_CTRL_OUTEN  2
`define TCP_CTRL_MODE_LO 3
`define TCP_CTRL_MODE_HI 4
`define TCP_CTRL_PRE_LO 5
`define TCP_CTRL_PRE_HI 7

// ----------------------------------------
// Modes and values
// ----------------------------------------
`define TCP_MODE_EVENT 2'h0
`define TCP_MODE_COMP  2'h1
`define TCP_MODE_PWM   2'h2
`define TCP_CNT_RST    16'h0001
`define TCP_CNT_ZERO   16'h0000
`define TCP_CNT_FULL   16'hFFFF
`define TCP_RLD_RST    16'h0000
`define TCP_HTRANS_NONSEQ 2'h2

`endif

// File: logic/tcp_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "tcp_defines.vh"

// Single timer: pin or comparator event counting, or single-output PWM.
// The bus only decodes the low address byte and always answers at once,
// so a master never sees a wait state or an error response.
module tcp_timer #(
  parameter NUM_IN      = 2,  // Counted inputs: pin then comparator
  parameter SYNC_STAGES = 3   // Two to settle, one to remember
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        timer_in,
  input  wire        comp_in,
  output reg         timer_out,
  output reg         timer_irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0]  ctrl_r;
  reg [15:0] count_r;
  reg [15:0] match_r;
  reg [15:0] reload_r;
  reg [6:0]  pre_cnt_r;
  reg        wr_pend_r;
  reg [7:0]  wr_addr_r;
  reg        reload_seen_r;

  wire       en_w   = ctrl_r[`TCP_CTRL_EN];
  wire       pol_w  = ctrl_r[`TCP_CTRL_POL];
  wire       oen_w  = ctrl_r[`TCP_CTRL_OUTEN];
  wire [1:0] mode_w = ctrl_r[`TCP_CTRL_MODE_HI:`TCP_CTRL_MODE_LO];
  wire [2:0] pre_w  = ctrl_r[`TCP_CTRL_PRE_HI:`TCP_CTRL_PRE_LO];

  // Size and burst type are not decoded: only whole words are supported
  wire       unused_hsize = ^hsize;

  // ----------------------------------------
  // Input synchronisers and edge detect
  // ----------------------------------------
  // Channel 0 is the timer input pin, channel 1 the comparator
  wire [NUM_IN-1:0] pin_raw = {comp_in, timer_in};
  wire [NUM_IN-1:0] pin_rise;
  wire [NUM_IN-1:0] pin_fall;

  // Stage 0 only feeds stage 1; edges judged on the last two stages.
  // Costs three cycles of latency, but no metastable level is ever counted.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_sync
      reg [SYNC_STAGES-1:0] sync_r;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_r <= {SYNC_STAGES{1'b0}};
        end else begin
          sync_r <= {sync_r[SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
      assign pin_rise[gi] = sync_r[SYNC_STAGES-2] & ~sync_r[SYNC_STAGES-1];
      assign pin_fall[gi] = ~sync_r[SYNC_STAGES-2] & sync_r[SYNC_STAGES-1];
    end
  endgenerate

  // Polarity 1 counts rising, 0 falling
  wire tin_edge = pol_w ? pin_rise[0] : pin_fall[0];
  wire cmp_edge = pol_w ? pin_rise[1] : pin_fall[1];

  // ----------------------------------------
  // Prescaler: divide by 2^pre in PWM mode
  // ----------------------------------------
  // Exponent 7 wraps the shifted one to zero, so the limit becomes 127,
  // which still gives the divide by 128 without a wider counter
  reg [6:0] pre_max;
  always @* begin
    pre_max = (7'h01 << pre_w) - 7'h01;
  end
  wire pre_tick = (pre_cnt_r == pre_max);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 7'h00;
    end else if (!en_w || mode_w != `TCP_MODE_PWM || pre_tick) begin
      pre_cnt_r <= 7'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  // Advance source per mode; counting modes skip prescaler
  reg adv;
  always @* begin
    adv = 1'b0;
    if (en_w) begin
      if (mode_w == `TCP_MODE_EVENT) begin
        adv = tin_edge;
      end else if (mode_w == `TCP_MODE_COMP) begin
        adv = cmp_edge;
      end else if (mode_w == `TCP_MODE_PWM) begin
        adv = pre_tick;
      end
    end
  end

  // Reload is judged before match, so a match equal to reload never
  // flips the output away from its period start level
  wire at_reload = (count_r == reload_r);
  wire do_reload = adv & at_reload;
  wire do_match  = adv & ~at_reload & (count_r == match_r) & (mode_w == `TCP_MODE_PWM);

  // ----------------------------------------
  // Bus write pipeline (AHB-Lite data phase)
  // ----------------------------------------
  // Address captured at the address edge; data arrives one cycle later
  // and is stored at the edge that closes the data phase
  wire addr_ok = hsel & hready & (htrans == `TCP_HTRANS_NONSEQ);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end
  wire wr_ctrl   = wr_pend_r && wr_addr_r == `TCP_OFF_CTRL;
  wire wr_count  = wr_pend_r && wr_addr_r == `TCP_OFF_COUNT;
  wire wr_match  = wr_pend_r && wr_addr_r == `TCP_OFF_MATCH;
  wire wr_reload = wr_pend_r && wr_addr_r == `TCP_OFF_RELOAD;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Software is expected to disable the timer before rewriting these;
  // a change while running takes effect on the very next advance
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r   <= 8'h00;
      match_r  <= `TCP_RLD_RST;
      reload_r <= `TCP_RLD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[7:0];
      end
      if (wr_match) begin
        match_r <= hwdata[15:0];
      end
      if (wr_reload) begin
        reload_r <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Counter; software write only seeds first pass
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r       <= `TCP_CNT_RST;
      reload_seen_r <= 1'b0;
    end else if (wr_count) begin
      count_r       <= hwdata[15:0];
      reload_seen_r <= 1'b0;
    end else if (do_reload) begin
      count_r       <= `TCP_CNT_RST;
      reload_seen_r <= 1'b1;
    end else if (adv) begin
      if (count_r == `TCP_CNT_FULL) begin
        count_r <= `TCP_CNT_ZERO;
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
    // Disabled: adv is low so the count holds
  end

  // ----------------------------------------
  // Output pin and interrupt
  // ----------------------------------------
  // Disabled output sits at its polarity level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_out <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= do_reload;
      if (!en_w) begin
        timer_out <= pol_w;
      end else if (mode_w == `TCP_MODE_PWM) begin
        if (do_reload) begin
          timer_out <= pol_w;
        end else if (do_match) begin
          timer_out <= ~pol_w;
        end
      end else if (do_reload && oen_w) begin
        timer_out <= ~timer_out;
      end
    end
  end

  // ----------------------------------------
  // Bus read and response; zero wait states
  // ----------------------------------------
  // Read word chosen in the address phase; unmapped reads give zero
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    if (haddr[7:0] == `TCP_OFF_CTRL) begin
      rd_nxt = {24'h000000, ctrl_r};
    end else if (haddr[7:0] == `TCP_OFF_COUNT) begin
      rd_nxt = {16'h0000, count_r};
    end else if (haddr[7:0] == `TCP_OFF_MATCH) begin
      rd_nxt = {16'h0000, match_r};
    end else if (haddr[7:0] == `TCP_OFF_RELOAD) begin
      rd_nxt = {16'h0000, reload_r};
    end else if (haddr[7:0] == `TCP_OFF_STATUS) begin
      rd_nxt = {30'h00000000, reload_seen_r, timer_out};
    end
  end

  // Registered at the address edge so the word stands in the data phase;
  // the count seen is the one of the address cycle, not of the data cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // Every transfer accepted at once with an OKAY answer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: tb/tcp_pins.sv
`timescale 1ns/10ps
`default_nettype none
module tcp_pins (
  input  wire logic hclk,
  output var logic  timer_in,
  output var logic  comp_in
);
  // ----------------------------------
  // Pin and comparator driver
  // ----------------------------------
  initial begin
    timer_in = 1'b0;
    comp_in = 1'b0;
  end
  // Four clocks per level keeps inside the quarter-rate limit
  task automatic edges(input logic c, input int n);
    repeat (n) begin
      @(posedge hclk);
      if (c) comp_in <= ~comp_in;
      else timer_in <= ~timer_in;
      repeat (3) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// File: tb/tcp_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module tcp_timer_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timer_out,
  input wire logic        timer_irq
);
  // ----------------------------------
  // Control shadow and properties
  // ----------------------------------
  logic [7:0] a_r;
  logic [7:0] ctl_r;
  logic       w_r;
  wire        tk = hsel && hready && htrans == 2'h2;
  wire        look = tk && !hwrite;
  // Shadow lands on the same edge as the real control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_r <= 8'h00;
      w_r <= 1'b0;
      ctl_r <= 8'h00;
    end else begin
      w_r <= tk && hwrite;
      if (tk) a_r <= haddr[7:0];
      if (w_r && a_r == 8'h00) ctl_r <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not ready and okay");
  irq_pulse_a: assert property (timer_irq |=> !timer_irq)
    else $error("interrupt held over one cycle");
  gap_zero_a: assert property (look && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  count_width_a: assert property (look && haddr[7:0] == 8'h04 |=> hrdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  status_pin_a: assert property (look && haddr[7:0] == 8'h10 |=> hrdata[0] == $past(timer_out))
    else $error("status pin bit wrong");
  idle_quiet_a: assert property (!ctl_r[0] && !$past(ctl_r[0]) && !$past(ctl_r[0], 2) |-> !timer_irq)
    else $error("interrupt while disabled");
  idle_level_a: assert property (!ctl_r[0] && $past(ctl_r[1:0]) == ctl_r[1:0] |-> timer_out == ctl_r[1])
    else $error("idle output not at polarity");
  cnt_toggle_a: assert property (ctl_r[0] && !ctl_r[4] && $past(ctl_r) == ctl_r && $changed(timer_out)
    |-> ##[0:1] timer_irq)
    else $error("output changed away from reload");
  cover property (timer_irq && ctl_r[4]);
  cover property (timer_irq && ctl_r[4:3] == 2'h1);
  cover property (timer_irq && ctl_r[4:3] == 2'h0);
endmodule
bind tcp_timer tcp_timer_props i_tcp_timer_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_out, .timer_irq);
`default_nettype wire

// File: tb/tcp_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module tcp_timer_test;
  logic        hclk, hresetn, hsel, hwrite, timer_in, comp_in;
  logic        hreadyout, hresp, timer_out, timer_irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  int          fail_count, checked, cyc, irqs, n;
  wire         hready = hreadyout;
  tcp_timer i_tcp_timer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .timer_in, .comp_in, .timer_out, .timer_irq);
  tcp_pins i_tcp_pins (.hclk, .timer_in, .comp_in);
  // ----------------------------------
  // Bus tasks and scenarios
  // ----------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Single transfer; nothing moves until hready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // Mode, start count and reload, enable written last
  task automatic setup(input logic [7:0] c, input logic [15:0] s, input logic [15:0] m, input logic [15:0] l);
    wr(8'h00, {24'h0, c & 8'hFE});
    wr(8'h04, {16'h0, s});
    wr(8'h08, {16'h0, m});
    wr(8'h0C, {16'h0, l});
    wr(8'h00, {24'h0, c});
  endtask
  // Rising pin edges counted, falling ignored, output inverts at reload
  task automatic t_event();
    setup(8'h07, 16'h0001, 16'h0000, 16'h0003);
    i_tcp_pins.edges(1'b0, 4);
    rd(8'h04, 32'h3);
    chk({31'h0, timer_out}, 32'h1);
    i_tcp_pins.edges(1'b1, 2);
    rd(8'h04, 32'h3);
    n = irqs;
    i_tcp_pins.edges(1'b0, 2);
    rd(8'h04, 32'h1);
    chk(32'(irqs - n), 32'h1);
    chk({31'h0, timer_out}, 32'h0);
    i_tcp_pins.edges(1'b0, 2);
    rd(8'h04, 32'h2);
  endtask
  // Falling comparator edges from an odd start, across the wrap
  task automatic t_comp();
    setup(8'h09, 16'hFFFF, 16'h0000, 16'h0002);
    i_tcp_pins.edges(1'b1, 1);
    rd(8'h04, 32'hFFFF);
    i_tcp_pins.edges(1'b1, 1);
    rd(8'h04, 32'h0);
    i_tcp_pins.edges(1'b0, 2);
    i_tcp_pins.edges(1'b1, 4);
    rd(8'h04, 32'h2);
    n = irqs;
    i_tcp_pins.edges(1'b1, 2);
    rd(8'h04, 32'h1);
    chk(32'(irqs - n), 32'h1);
    chk({31'h0, timer_out}, 32'h0);
  endtask
  // Period and active time measured between two reloads, then hold
  task automatic t_pwm(input logic [7:0] c, input int pre);
    int p;
    int a;
    p = 0;
    a = 0;
    setup(c, 16'h0003, 16'h0003, 16'h0006);
    @(posedge hclk iff timer_irq === 1'b1);
    chk({31'h0, timer_out}, {31'h0, c[1]});
    do begin
      @(posedge hclk);
      p++;
      if (timer_out !== c[1]) a++;
    end while (timer_irq !== 1'b1);
    chk(32'(p), 32'(6 * pre));
    chk(32'(a), 32'(3 * pre));
    wr(8'h00, {24'h0, c & 8'hFE});
    wr(8'h04, 32'h7);
    repeat (20) @(posedge hclk);
    rd(8'h04, 32'h7);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Clock, cycle ceiling and interrupt tally
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (timer_irq === 1'b1) irqs++;
    if (cyc == 6000) begin
      fail_count++;
      wrap_up();
    end
  end
  // Reset, register map, then each mode in turn
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h04, 32'h1);
    rd(8'h10, 32'h0);
    wr(8'h14, 32'h5A);
    rd(8'h14, 32'h0);
    t_event();
    t_comp();
    t_pwm(8'h13, 1);
    t_pwm(8'h31, 2);
    wrap_up();
  end
endmodule
`default_nettype wire
